// file: verilog/reset_state_pkg.sv
// constants and types shared by the reset initial state logic
package reset_state_pkg;

   // ------------------------------------------------------------
   // widths and initial values
   // ------------------------------------------------------------
   localparam int          DATA_W        = 8;
   localparam int          PC_W          = 13;
   localparam int          SP_W          = 4;
   localparam int          NUM_PORTS     = 6;
   localparam int          NUM_INTC      = 4;
   localparam int          WDOG_W        = 16;
   localparam int          TB_W          = 16;
   localparam int          TO_BIT        = 5;
   localparam int          PWRDN_BIT     = 4;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [7:0]  PORT_INIT     = 8'hff;
   localparam logic [7:0]  STATUS_INIT   = 8'h00;
   localparam logic [7:0]  ACC_POR_FILL  = 8'h00;
   localparam logic [12:0] PC_INIT       = 13'h0000;
   localparam logic [3:0]  SP_TOP        = 4'h0;
   localparam logic [15:0] CNT_ZERO      = 16'h0000;
   localparam logic [15:0] CNT_ONE       = 16'h0001;

   // ------------------------------------------------------------
   // reset kinds, encoded by the classifier
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      RK_NONE      = 3'b000,
      RK_POWER_ON  = 3'b001,
      RK_PIN_RUN   = 3'b010,
      RK_PIN_SLEEP = 3'b011,
      RK_TMO_RUN   = 3'b100,
      RK_TMO_SLEEP = 3'b101
   } reset_kind_t;

   // reset sources sampled each cycle
   typedef struct packed {
      logic power_on;
      logic pin;
      logic low_voltage;
      logic watchdog;
      logic sleeping;
   } reset_cause_t;

   // core register writes from the executing program
   typedef struct packed {
      logic       we;
      logic [7:0] data;
   } byte_write_t;

endpackage

// file: verilog/reset_kind_decode.sv
// classifies sampled reset causes into one reset kind
`timescale 1ns/100ps
`default_nettype none
module reset_kind_decode
   import reset_state_pkg::*;
(
   input  wire  reset_state_pkg::reset_cause_t cause,
   output var   reset_state_pkg::reset_kind_t  kind
);

   // ------------------------------------------------------------
   // priority: power-on first, then pin/low voltage, then watchdog
   // ------------------------------------------------------------
   always_comb begin
      if (cause.power_on) begin
         kind = RK_POWER_ON;
      end else if (cause.pin && cause.sleeping) begin
         kind = RK_PIN_SLEEP;
      end else if (cause.pin || cause.low_voltage) begin
         kind = RK_PIN_RUN;
      end else if (cause.watchdog && cause.sleeping) begin
         kind = RK_TMO_SLEEP;
      end else if (cause.watchdog) begin
         kind = RK_TMO_RUN;
      end else begin
         kind = RK_NONE;
      end
   end

endmodule
`default_nettype wire

// file: verilog/reset_initial_state_logic.sv
// applies per-register initial state according to the kind of reset
`timescale 1ns/100ps
`default_nettype none
module reset_initial_state_logic
   import reset_state_pkg::*;
(
   input  wire  logic                         clk,
   input  wire  logic                         reset_n,
   input  wire  reset_state_pkg::reset_cause_t cause,
   input  wire  logic                         sleep_enter,
   input  wire  logic                         watchdog_clear,
   input  wire  reset_state_pkg::byte_write_t  acc_wr,
   input  wire  reset_state_pkg::byte_write_t  table_pointer_wr,
   input  wire  reset_state_pkg::byte_write_t  table_high_wr,
   input  wire  reset_state_pkg::byte_write_t  intc_wr,
   input  wire  logic [1:0]                   intc_sel,
   input  wire  reset_state_pkg::byte_write_t  port_wr,
   input  wire  reset_state_pkg::byte_write_t  port_dir_wr,
   input  wire  logic [2:0]                   port_sel,
   input  wire  logic                         timer_on_wr,
   input  wire  logic                         pc_step,
   input  wire  logic                         sp_push,
   output logic                               watchdog_timeout_flag,
   output logic                               power_down_flag,
   output logic [7:0]                         status_out,
   output logic [7:0]                         program_counter_low_byte,
   output logic [12:0]                        pc_out,
   output logic [3:0]                         sp_out,
   output logic                               int_enable,
   output logic [31:0]                        intc_out,
   output logic [47:0]                        port_data_out,
   output logic [47:0]                        port_dir_out,
   output logic                               timers_on,
   output logic [15:0]                        watchdog_counter,
   output logic [15:0]                        timebase_out,
   output logic [7:0]                         acc_out,
   output logic [7:0]                         table_pointer_low,
   output logic [7:0]                         table_high_byte,
   output logic [2:0]                         last_reset_kind
);
   // ------------------------------------------------------------
   // reset kind classification
   // ------------------------------------------------------------
   reset_kind_t kind;
   logic        any_reset;
   logic        defined_init;
   logic        retain_all;
   reset_kind_decode u_decode (
      .cause (cause),
      .kind  (kind)
   );
   // reset groups that steer the register blocks
   assign any_reset    = (kind != RK_NONE);
   assign retain_all   = (kind == RK_TMO_SLEEP);
   assign defined_init = any_reset && !retain_all;

   // byte write helper used by several retained registers
   function automatic logic [7:0] upd(input byte_write_t w, input logic [7:0] cur);
      upd = w.we ? w.data : cur;
   endfunction

   // ------------------------------------------------------------
   // status flags and status byte
   // ------------------------------------------------------------
   logic       to_r;
   logic       pwrdn_r;
   logic [7:0] status_r;
   logic [2:0] kind_r;
   // flag update per reset kind; sleep entry and watchdog clear act normally
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         to_r    <= 1'b0;
         pwrdn_r <= 1'b0;
      end else begin
         case (kind)
            RK_POWER_ON: begin
               to_r    <= 1'b0;
               pwrdn_r <= 1'b0;
            end
            RK_PIN_RUN: begin
               to_r    <= to_r;
               pwrdn_r <= pwrdn_r;
            end
            RK_PIN_SLEEP: begin
               to_r    <= 1'b0;
               pwrdn_r <= 1'b1;
            end
            RK_TMO_RUN: begin
               to_r    <= 1'b1;
            end
            RK_TMO_SLEEP: begin
               to_r    <= 1'b1;
               pwrdn_r <= 1'b1;
            end
            default: begin
               if (sleep_enter) begin
                  to_r    <= 1'b0;
                  pwrdn_r <= 1'b1;
               end else if (watchdog_clear) begin
                  to_r    <= 1'b0;
                  pwrdn_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // kind of the latest reset, held until the next one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         kind_r <= RK_POWER_ON;
      end else if (any_reset) begin
         kind_r <= kind;
      end
   end
   // status byte image with flags in place; undefined bits read as zero
   always_comb begin
      status_r            = STATUS_INIT;
      status_r[TO_BIT]    = to_r;
      status_r[PWRDN_BIT] = pwrdn_r;
   end

   // ------------------------------------------------------------
   // program counter and stack pointer
   // ------------------------------------------------------------
   logic [12:0] pc_r;
   logic [3:0]  sp_r;

   // every reset kind clears the counter, idle/sleep watchdog included
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_r <= PC_INIT;
      end else if (any_reset) begin
         pc_r <= PC_INIT;
      end else if (pc_step) begin
         pc_r <= pc_r + 13'h0001;
      end
   end

   // stack pointer returns to top on every reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sp_r <= SP_TOP;
      end else if (any_reset) begin
         sp_r <= SP_TOP;
      end else if (sp_push) begin
         sp_r <= sp_r + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // interrupt control
   // ------------------------------------------------------------
   logic [7:0] intc_r [NUM_INTC];
   logic       int_en_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_INTC; i++) begin
            intc_r[i] <= ZERO_BYTE;
         end
      end else if (defined_init) begin
         for (int i = 0; i < NUM_INTC; i++) begin
            intc_r[i] <= ZERO_BYTE;
         end
      end else if (!any_reset && intc_wr.we) begin
         intc_r[intc_sel] <= intc_wr.data;
      end
   end

   // global enable follows bit 0 of the first control byte
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_en_r <= 1'b0;
      end else if (defined_init) begin
         int_en_r <= 1'b0;
      end else if (!any_reset && intc_wr.we && intc_sel == 2'd0) begin
         int_en_r <= intc_wr.data[0];
      end
   end

   // ------------------------------------------------------------
   // port data and direction
   // ------------------------------------------------------------
   logic [7:0] port_r [NUM_PORTS];
   logic [7:0] pdir_r [NUM_PORTS];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_r[i] <= PORT_INIT;
            pdir_r[i] <= PORT_INIT;
         end
      end else if (defined_init) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_r[i] <= PORT_INIT;
            pdir_r[i] <= PORT_INIT;
         end
      end else if (!any_reset && port_sel < 3'(NUM_PORTS)) begin
         port_r[port_sel] <= upd(port_wr, port_r[port_sel]);
         pdir_r[port_sel] <= upd(port_dir_wr, pdir_r[port_sel]);
      end
   end

   // ------------------------------------------------------------
   // timers, watchdog and time base
   // ------------------------------------------------------------
   logic        timers_r;
   logic [15:0] wdog_r;
   logic [15:0] tb_r;
   // timers switched on by the program, off at every defined reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timers_r <= 1'b0;
      end else if (defined_init) begin
         timers_r <= 1'b0;
      end else if (!any_reset && timer_on_wr) begin
         timers_r <= 1'b1;
      end
   end
   // counters cleared by any reset, watchdog counts on the next edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdog_r <= CNT_ZERO;
         tb_r   <= CNT_ZERO;
      end else if (any_reset || watchdog_clear) begin
         wdog_r <= CNT_ZERO;
         tb_r   <= any_reset ? CNT_ZERO : tb_r + CNT_ONE;
      end else begin
         wdog_r <= wdog_r + CNT_ONE;
         tb_r   <= tb_r + CNT_ONE;
      end
   end

   // ------------------------------------------------------------
   // accumulator and table registers
   // ------------------------------------------------------------
   logic [7:0] acc_r;
   logic [7:0] table_lo_r;
   logic [7:0] table_hi_r;
   // undefined after power-on (fill value), held over other resets
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_r      <= ACC_POR_FILL;
         table_lo_r <= ACC_POR_FILL;
         table_hi_r <= ACC_POR_FILL;
      end else if (kind == RK_POWER_ON) begin
         acc_r      <= ACC_POR_FILL;
         table_lo_r <= ACC_POR_FILL;
         table_hi_r <= ACC_POR_FILL;
      end else if (!any_reset) begin
         acc_r      <= upd(acc_wr, acc_r);
         table_lo_r <= upd(table_pointer_wr, table_lo_r);
         table_hi_r <= upd(table_high_wr, table_hi_r);
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_timeout_flag    <= 1'b0;
         power_down_flag          <= 1'b0;
         status_out               <= STATUS_INIT;
         program_counter_low_byte <= ZERO_BYTE;
         pc_out                   <= PC_INIT;
         sp_out                   <= SP_TOP;
         int_enable               <= 1'b0;
         intc_out                 <= '0;
         port_data_out            <= '1;
         port_dir_out             <= '1;
         timers_on                <= 1'b0;
         watchdog_counter         <= CNT_ZERO;
         timebase_out             <= CNT_ZERO;
         acc_out                  <= ACC_POR_FILL;
         table_pointer_low        <= ACC_POR_FILL;
         table_high_byte          <= ACC_POR_FILL;
         last_reset_kind          <= RK_POWER_ON;
      end else begin
         watchdog_timeout_flag    <= to_r;
         power_down_flag          <= pwrdn_r;
         status_out               <= status_r;
         program_counter_low_byte <= pc_r[7:0];
         pc_out                   <= pc_r;
         sp_out                   <= sp_r;
         int_enable               <= int_en_r;
         intc_out                 <= {intc_r[3], intc_r[2], intc_r[1], intc_r[0]};
         port_data_out            <= {port_r[5], port_r[4], port_r[3], port_r[2], port_r[1], port_r[0]};
         port_dir_out             <= {pdir_r[5], pdir_r[4], pdir_r[3], pdir_r[2], pdir_r[1], pdir_r[0]};
         timers_on                <= timers_r;
         watchdog_counter         <= wdog_r;
         timebase_out             <= tb_r;
         acc_out                  <= acc_r;
         table_pointer_low        <= table_lo_r;
         table_high_byte          <= table_hi_r;
         last_reset_kind          <= kind_r;
      end
   end

endmodule
`default_nettype wire

// file: sim/reset_state_props.sv
// assertion checker for the reset initial state logic
`timescale 1ns/100ps
`default_nettype none
module reset_state_props
   import reset_state_pkg::*;
(
   input wire logic                          clk,
   input wire logic                          reset_n,
   input wire reset_state_pkg::reset_cause_t cause,
   input wire logic                          watchdog_timeout_flag,
   input wire logic                          power_down_flag,
   input wire logic [7:0]                    status_out,
   input wire logic [7:0]                    program_counter_low_byte,
   input wire logic [12:0]                   pc_out,
   input wire logic [3:0]                    sp_out,
   input wire logic                          int_enable,
   input wire logic [31:0]                   intc_out,
   input wire logic [47:0]                   port_data_out,
   input wire logic [47:0]                   port_dir_out,
   input wire logic                          timers_on,
   input wire logic [15:0]                   watchdog_counter,
   input wire logic [15:0]                   timebase_out,
   input wire logic [7:0]                    acc_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ------------------------------------------------------------
   // reset kinds by priority, two edges ahead of the outputs
   // ------------------------------------------------------------
   logic any_rst, por, pin_slp, keep_fl, tmo_run, tmo_slp;
   assign any_rst = cause.power_on | cause.pin | cause.low_voltage | cause.watchdog;
   assign por     = cause.power_on;
   assign pin_slp = !por & cause.pin & cause.sleeping;
   assign keep_fl = !por & !pin_slp & (cause.pin | cause.low_voltage);
   assign tmo_run = !por & !cause.pin & !cause.low_voltage & cause.watchdog & !cause.sleeping;
   assign tmo_slp = !por & !cause.pin & !cause.low_voltage & cause.watchdog & cause.sleeping;

   por_flags_a: assert property (
      $past(reset_n,2) && $past(por,2) |-> !watchdog_timeout_flag && !power_down_flag && acc_out == 8'h00)
      else $error("flags or acc not cleared after power-on");
   keep_flags_a: assert property (
      $past(reset_n,2) && $past(keep_fl,2) |-> $stable(watchdog_timeout_flag) && $stable(power_down_flag))
      else $error("flags changed by running pin reset");
   timeout_run_a: assert property (
      $past(reset_n,2) && $past(tmo_run,2) |-> watchdog_timeout_flag && $stable(power_down_flag))
      else $error("wrong flags after running timeout");
   timeout_sleep_a: assert property (
      $past(reset_n,2) && $past(tmo_slp,2) |-> watchdog_timeout_flag && power_down_flag
      && $stable(intc_out) && $stable(port_data_out) && $stable(port_dir_out) && $stable(timers_on))
      else $error("sleeping timeout state wrong");
   pin_sleep_a: assert property (
      $past(reset_n,2) && $past(pin_slp,2) |-> !watchdog_timeout_flag && power_down_flag)
      else $error("wrong flags after sleeping pin reset");
   status_map_a: assert property (
      status_out == {2'b00, watchdog_timeout_flag, power_down_flag, 4'h0})
      else $error("status byte does not carry flags");
   pc_clear_a: assert property (
      $past(reset_n,2) && $past(any_rst,2) |-> program_counter_low_byte == 8'h00 && pc_out == 13'h0000
      && sp_out == 4'h0)
      else $error("pc or sp not cleared");
   init_vals_a: assert property (
      $past(reset_n,2) && $past(any_rst && !tmo_slp,2) |-> !int_enable && intc_out == 32'h0000_0000
      && !timers_on && port_data_out == 48'hffff_ffff_ffff && port_dir_out == 48'hffff_ffff_ffff)
      else $error("initial values not loaded");
   counter_restart_a: assert property (
      $past(reset_n,2) && $past(any_rst,2) && !$past(any_rst) |-> watchdog_counter == 16'h0000
      && timebase_out == 16'h0000 ##1 watchdog_counter == 16'h0001)
      else $error("counters not cleared and restarted");

   // main scenarios reached
   cover property (tmo_slp);
   cover property (pin_slp);
   cover property (por && cause.watchdog);
endmodule
bind reset_initial_state_logic reset_state_props props (.clk, .reset_n, .cause, .watchdog_timeout_flag,
   .power_down_flag, .status_out, .program_counter_low_byte, .pc_out, .sp_out, .int_enable, .intc_out,
   .port_data_out, .port_dir_out, .timers_on, .watchdog_counter, .timebase_out, .acc_out);
`default_nettype wire

// file: sim/tb.sv
// self-checking testbench for the reset initial state logic
`timescale 1ns/100ps
`default_nettype none
module tb;
   import reset_state_pkg::*;
   typedef struct packed {reset_cause_t c; logic to; logic pd; reset_kind_t k;} row_t;
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   reset_cause_t  cause;
   logic          sleep_enter, watchdog_clear, timer_on_wr, pc_step, sp_push;
   byte_write_t   acc_wr, table_pointer_wr, table_high_wr, intc_wr, port_wr, port_dir_wr;
   logic [1:0]    intc_sel;
   logic [2:0]    port_sel;
   logic          watchdog_timeout_flag, power_down_flag, int_enable, timers_on;
   logic [7:0]    status_out, program_counter_low_byte, acc_out, table_pointer_low, table_high_byte;
   logic [12:0]   pc_out;
   logic [3:0]    sp_out;
   logic [31:0]   intc_out;
   logic [47:0]   port_data_out, port_dir_out;
   logic [15:0]   watchdog_counter, timebase_out;
   logic [2:0]    last_reset_kind;
   int            err_count = 0;
   int            n_compared = 0;
   row_t          rows [9] = '{'{5'b10000, 1'b0, 1'b0, RK_POWER_ON}, '{5'b00010, 1'b1, 1'b0, RK_TMO_RUN},
      '{5'b01000, 1'b1, 1'b0, RK_PIN_RUN}, '{5'b00011, 1'b1, 1'b1, RK_TMO_SLEEP},
      '{5'b00100, 1'b1, 1'b1, RK_PIN_RUN}, '{5'b01001, 1'b0, 1'b1, RK_PIN_SLEEP},
      '{5'b00010, 1'b1, 1'b1, RK_TMO_RUN}, '{5'b01000, 1'b1, 1'b1, RK_PIN_RUN},
      '{5'b11111, 1'b0, 1'b0, RK_POWER_ON}};

   reset_initial_state_logic dut (.clk, .reset_n, .cause, .sleep_enter, .watchdog_clear, .acc_wr,
      .table_pointer_wr, .table_high_wr, .intc_wr, .intc_sel, .port_wr, .port_dir_wr, .port_sel, .timer_on_wr,
      .pc_step, .sp_push,
      .watchdog_timeout_flag, .power_down_flag, .status_out, .program_counter_low_byte, .pc_out, .sp_out,
      .int_enable, .intc_out, .port_data_out, .port_dir_out, .timers_on, .watchdog_counter,
      .timebase_out, .acc_out, .table_pointer_low, .table_high_byte, .last_reset_kind);

   // 10 MHz clock
   always #50 clk = ~clk;

   // ------------------------------------------------------------
   // driver and compare helpers
   // ------------------------------------------------------------
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task idle();
      cause = '0;
      sleep_enter = 1'b0;
      watchdog_clear = 1'b0;
      timer_on_wr = 1'b0;
      pc_step = 1'b0;
      sp_push = 1'b0;
      acc_wr = '0;
      table_pointer_wr = '0;
      table_high_wr = '0;
      intc_wr = '0;
      port_wr = '0;
      port_dir_wr = '0;
      intc_sel = 2'd0;
      port_sel = 3'd0;
   endtask
   // one cycle of a cause, then wait out the two-edge latency
   task apply(input reset_cause_t c);
      cause = c;
      step(1);
      cause = '0;
      step(1);
   endtask
   task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog on the whole run, well above the expected 60 cycles or so
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      idle();
      step(16);
      reset_n = 1'b1;
      step(2);
      foreach (rows[i]) begin
         apply(rows[i].c);
         chk(watchdog_timeout_flag, rows[i].to, "timeout flag");
         chk(power_down_flag, rows[i].pd, "power-down flag");
         chk(status_out, {2'b00, rows[i].to, rows[i].pd, 4'h0}, "status");
         chk(last_reset_kind, rows[i].k, "kind");
      end
      $display("flag table done");
      // program state, then a sleeping timeout keeps it except pc, sp and the counters
      acc_wr = '{1'b1, 8'ha5};
      table_pointer_wr = '{1'b1, 8'h5a};
      table_high_wr = '{1'b1, 8'h3c};
      intc_wr = '{1'b1, 8'h81};
      port_wr = '{1'b1, 8'h12};
      port_dir_wr = '{1'b1, 8'h34};
      port_sel = 3'd5;
      timer_on_wr = 1'b1;
      pc_step = 1'b1;
      sp_push = 1'b1;
      step(1);
      idle();
      step(1);
      apply(5'b00011);
      chk(intc_out[7:0], 8'h81, "intc kept");
      chk(int_enable, 1'b1, "int enable kept");
      chk({port_data_out[47:40], port_dir_out[47:40]}, 16'h1234, "port kept");
      chk(timers_on, 1'b1, "timers kept");
      chk({pc_out, sp_out}, 17'h0, "pc sp");
      chk({watchdog_counter, timebase_out}, 32'h0, "counters");
      step(1);
      chk(watchdog_counter, 16'h0001, "counting");
      apply(5'b01000);
      chk({intc_out, 7'h0, int_enable}, 40'h0, "intc cleared");
      chk({port_data_out, port_dir_out}, {96{1'b1}}, "ports input");
      chk(timers_on, 1'b0, "timers off");
      chk({acc_out, table_pointer_low, table_high_byte}, 24'ha55a3c, "acc kept");
      chk(program_counter_low_byte, 8'h00, "pc low");
      apply(5'b10000);
      chk({acc_out, table_pointer_low, table_high_byte}, 24'h0, "acc power-on");
      $display("retention done");
      // writes in a reset cycle and to port select 6 are dropped
      cause = 5'b01000;
      acc_wr = '{1'b1, 8'h77};
      step(1);
      idle();
      port_wr = '{1'b1, 8'h00};
      port_sel = 3'd6;
      step(1);
      idle();
      step(1);
      chk(acc_out, 8'h00, "acc write in reset");
      chk(port_data_out, 48'hffff_ffff_ffff, "port sel 6");
      // sleep entry and watchdog clear drive the flags
      sleep_enter = 1'b1;
      step(1);
      sleep_enter = 1'b0;
      step(1);
      chk({watchdog_timeout_flag, power_down_flag}, 2'b01, "sleep entry");
      watchdog_clear = 1'b1;
      step(1);
      watchdog_clear = 1'b0;
      step(1);
      chk({watchdog_timeout_flag, power_down_flag}, 2'b00, "watchdog clear");
      $display("flag events done");
      // asynchronous reset in mid-run
      apply(5'b00011);
      reset_n = 1'b0;
      #1 chk({watchdog_timeout_flag, power_down_flag}, 2'b00, "async flags");
      chk(port_dir_out, 48'hffff_ffff_ffff, "async ports");
      step(2);
      reset_n = 1'b1;
      step(3);
      chk(status_out, 8'h00, "status after reset");
      $display("async reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
